// File: hdl/tpfdr_fifo.sv
// Write FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module tpfdr_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input  wire logic   clock_i,
   input  wire logic   resetn_i,
   tpfdr_fifo_if.store f
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

   if (DEPTH < 2 || W < 1) begin : g_bad
      $error("tpfdr_fifo: DEPTH must be at least 2 and W at least 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } tpfdr_fifo_state_type;

   tpfdr_fifo_state_type s_r;
   tpfdr_fifo_state_type s_nxt;
   logic                 push;
   logic                 pop;

   assign f.in_ready  = s_r.cnt != FULL;
   assign f.out_valid = s_r.cnt != '0;
   assign f.out_data  = s_r.mem[s_r.rp];
   assign push        = f.in_valid && f.in_ready;
   assign pop         = f.out_valid && f.out_ready;

   // Pointers wrap by compare so any depth of 2 or more works, not only powers of two
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = f.in_data;
         s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   a_fifo_bound: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_r.cnt == FULL |=> s_r.cnt <= FULL)
      else $error("write FIFO count passed its depth");
endmodule
`default_nettype wire

// File: hdl/tpfdr_fifo_if.sv
// Valid/ready carrier between the target and its write FIFO
`timescale 1ns/1ns
`default_nettype none
interface tpfdr_fifo_if #(
   parameter int W = 8
);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport fill (output in_valid, in_data, out_ready,
                 input  in_ready, out_valid, out_data);
   modport store (input  in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// File: hdl/tpfdr_pkg.sv
// Shared constants and types of the target FIFO and deferred read block
package tpfdr_pkg;

   // Default widths and depths
   localparam int ADDR_W_DEF     = 18;
   localparam int FIFO_DEPTH_DEF = 4;

   // Bus commands taken by the target
   localparam logic [3:0] CMD_MEM_READ  = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [3:0] CMD_MEM_WRINV = 4'hf;

   // Second window: core registers, then the interface registers
   localparam logic [11:0] CORE_REG_LAST = 12'h0fc;
   localparam logic [11:0] IFREG_FIRST   = 12'h800;
   localparam logic [11:0] IFREG_LAST    = 12'h81c;
   localparam int          IFREG_COUNT   = 8;
   localparam int          IFREG_NE_BIT  = 30;

   // Timing in clock cycles of the bus clock
   localparam int ZERO_READ_CYC     = 3;
   localparam int DEFER_LAUNCH_CYC  = 4;
   localparam int DEFER_PRESENT_CYC = 4;

   // Longest core access time of a deferred read, in core clocks
   localparam logic [6:0] CORE_SW_MAX = 7'h06;
   localparam logic [6:0] CORE_DW_MAX = 7'h0e;

   // Extra core clocks allowed while the core contends for its RAM
   localparam logic [6:0] PRIO_SW_EXTRA   = 7'h03;
   localparam logic [6:0] PRIO_DW_EXTRA   = 7'h06;
   localparam logic [6:0] NOPRIO_SW_EXTRA = 7'h43;
   localparam logic [6:0] NOPRIO_DW_EXTRA = 7'h4a;

   // Answer to one bus request
   typedef enum logic [1:0] {
      ANS_DONE,
      ANS_RETRY,
      ANS_ABORT
   } tpfdr_ans_type;

endpackage

// File: hdl/tpfdr_target.sv
// Bus target: write FIFO to the terminal core and deferred reads
//
// What this block does
// - Deferred reads that run past the stated clock budget set late_o
// - Empty or upper-register reads: three clocks, zeros
// - Priority access: up to 3/6 extra clocks
// - No priority: up to 67/74 extra clocks
// - Priority-access input picks the contention limit
// - Core memory and register writes enter FIFO
// - Interface register writes bypass the FIFO
// - Single-byte word write to memory aborts
// - Single-byte word write to registers aborts
// - Registers take lower word only
// - Write-and-invalidate acts as plain write
// - Write bursts stall, never terminate early
// - Queue read only when FIFO empty, none pending
// - Retry repeats until data present, then complete
// - Single-byte register reads abort; memory reads whole
// - First interface register bit 30 shows FIFO not empty
`timescale 1ns/1ns
`default_nettype none
module tpfdr_target #(
   parameter int ADDR_W = tpfdr_pkg::ADDR_W_DEF,
   parameter int DEPTH  = tpfdr_pkg::FIFO_DEPTH_DEF
) (
   input  wire logic              clock_i,
   input  wire logic              resetn_i,
   input  wire logic              req_valid_i,
   input  wire logic [3:0]        req_cmd_i,
   input  wire logic              req_bar_i,
   input  wire logic [ADDR_W-1:0] req_off_i,
   input  wire logic [3:0]        req_be_n_i,
   input  wire logic [31:0]       req_wdata_i,
   output logic                   ans_valid_o,
   output logic [1:0]             ans_code_o,
   output logic [31:0]            ans_rdata_o,
   output logic                   core_req_o,
   output logic                   core_we_o,
   output logic                   core_reg_o,
   output logic [ADDR_W-2:0]      core_addr_o,
   output logic [15:0]            core_wdata_o,
   input  wire logic [15:0]       core_rdata_i,
   input  wire logic              core_ack_i,
   input  wire logic              core_active_i,
   input  wire logic              priority_access_i,
   output logic                   late_o
);
   localparam int EW = ADDR_W + 35;
   localparam int IW = ADDR_W - 2;

   if (ADDR_W < 12 || ADDR_W > 30) begin : g_bad
      $error("tpfdr_target: ADDR_W must lie between 12 and 30");
   end

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WR,
      ST_ZERO
   } tpfdr_main_type;

   typedef enum logic [2:0] {
      D_IDLE,
      D_LAUNCH,
      D_CORE,
      D_PRESENT,
      D_READY
   } tpfdr_defer_type;

   typedef struct packed {
      tpfdr_main_type                       st;
      logic [1:0]                           zcnt;
      logic                                 ans_valid;
      tpfdr_pkg::tpfdr_ans_type             ans_code;
      logic [31:0]                          ans_data;
      logic [tpfdr_pkg::IFREG_COUNT-1:0][31:0] ifreg;
      tpfdr_defer_type                      dst;
      logic [6:0]                           dcnt;
      logic                                 dreg;
      logic [IW-1:0]                        didx;
      logic [3:0]                           dbe;
      logic                                 dw;
      logic [31:0]                          ddata;
      logic                                 late;
      logic                                 creq;
      logic                                 cwe;
      logic                                 creg;
      logic                                 chi;
      logic [ADDR_W-2:0]                    caddr;
      logic [15:0]                          cwdata;
   } tpfdr_state_type;

   tpfdr_state_type s_r;
   tpfdr_state_type s_nxt;

   tpfdr_fifo_if #(.W(EW)) fq ();

   tpfdr_fifo #(
      .W     (EW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .f        (fq.store)
   );

   // Request decode
   logic [3:0]  be;
   logic        is_rd;
   logic        is_wr;
   logic        r_mem;
   logic        r_reg;
   logic        r_if;
   logic        r_core;
   logic        bad_be;
   logic        zero_rd;
   logic        take;
   logic        fifo_empty;
   logic        key_hit;
   logic [2:0]  if_idx;
   logic [31:0] if_rdata;

   assign be      = ~req_be_n_i;
   assign is_rd   = req_cmd_i == tpfdr_pkg::CMD_MEM_READ;
   assign is_wr   = req_cmd_i == tpfdr_pkg::CMD_MEM_WRITE
                 || req_cmd_i == tpfdr_pkg::CMD_MEM_WRINV;
   assign r_mem   = !req_bar_i;
   assign r_reg   = req_bar_i
                 && req_off_i <= ADDR_W'(tpfdr_pkg::CORE_REG_LAST);
   assign r_if    = req_bar_i
                 && req_off_i >= ADDR_W'(tpfdr_pkg::IFREG_FIRST)
                 && req_off_i <= ADDR_W'(tpfdr_pkg::IFREG_LAST);
   assign r_core  = r_mem || r_reg;
   assign bad_be  = (^be[1:0]) || (^be[3:2]);
   assign zero_rd = be == 4'h0 || (r_reg && be[1:0] == 2'h0);
   // The host lets go at the edge that sees the answer, so that
   // answer cycle must not take the still-raised request again
   assign take    = s_r.st == ST_IDLE && req_valid_i && !s_r.ans_valid;
   assign fifo_empty = !fq.out_valid;
   assign key_hit = s_r.dst == D_READY && s_r.dreg == r_reg
                 && s_r.didx == req_off_i[ADDR_W-1:2] && s_r.dbe == be;
   assign if_idx  = req_off_i[4:2];
   // Only the first interface word carries the live FIFO flag
   assign if_rdata = (if_idx == 3'h0)
                   ? {s_r.ifreg[0][31], !fifo_empty, s_r.ifreg[0][29:0]}
                   : s_r.ifreg[if_idx];

   // Host holds its request stable until answered, so the entry is
   // taken straight from the pins while the write waits for room
   assign fq.in_valid = s_r.st == ST_WR;
   assign fq.in_data  = {r_reg, req_off_i[ADDR_W-1:2], be, req_wdata_i};

   // Head of the FIFO, split into core words
   logic          e_reg;
   logic [IW-1:0] e_idx;
   logic [3:0]    e_be;
   logic [31:0]   e_data;
   logic          e_lo;
   logic          e_hi;
   logic          drain_ok;

   assign e_reg  = fq.out_data[EW-1];
   assign e_idx  = fq.out_data[EW-2 -: IW];
   assign e_be   = fq.out_data[35:32];
   assign e_data = fq.out_data[31:0];
   assign e_lo   = &e_be[1:0];
   assign e_hi   = !e_reg && (&e_be[3:2]);
   // A queued read goes to the core before any later write
   assign drain_ok = !s_r.creq && fq.out_valid
                  && s_r.dst != D_LAUNCH && s_r.dst != D_CORE;
   assign fq.out_ready = (drain_ok && !e_lo && !e_hi)
      || (s_r.creq && s_r.cwe && core_ack_i && (s_r.chi || !e_hi));

   // Core access budget of the running deferred read
   logic [6:0] extra;
   logic [6:0] limit;

   always_comb begin
      if (!core_active_i) begin
         extra = 7'h00;
      end else if (priority_access_i) begin
         extra = s_r.dw ? tpfdr_pkg::PRIO_DW_EXTRA
                        : tpfdr_pkg::PRIO_SW_EXTRA;
      end else begin
         extra = s_r.dw ? tpfdr_pkg::NOPRIO_DW_EXTRA
                        : tpfdr_pkg::NOPRIO_SW_EXTRA;
      end
      limit = (s_r.dw ? tpfdr_pkg::CORE_DW_MAX : tpfdr_pkg::CORE_SW_MAX)
            + extra;
   end

   function automatic tpfdr_state_type answer(
      input tpfdr_state_type          v,
      input tpfdr_pkg::tpfdr_ans_type code,
      input logic [31:0]              data
   );
      tpfdr_state_type r;
      r           = v;
      r.ans_valid = 1'b1;
      r.ans_code  = code;
      r.ans_data  = data;
      r.st        = ST_IDLE;
      return r;
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.ans_valid = 1'b0;

      unique case (s_r.st)
         ST_IDLE: begin
            if (take && is_rd) begin
               if (r_if) begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, if_rdata);
               end else if (r_reg && bad_be) begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_ABORT, 32'h0);
               end else if (r_core && zero_rd) begin
                  s_nxt.st   = ST_ZERO;
                  s_nxt.zcnt = 2'(tpfdr_pkg::ZERO_READ_CYC - 1);
               end else if (r_core && key_hit) begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, s_r.ddata);
                  s_nxt.dst = D_IDLE;
               end else if (r_core) begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_RETRY, 32'h0);
                  if (s_r.dst == D_IDLE && fifo_empty) begin
                     s_nxt.dst   = D_LAUNCH;
                     s_nxt.dcnt  = 7'(tpfdr_pkg::DEFER_LAUNCH_CYC - 1);
                     s_nxt.dreg  = r_reg;
                     s_nxt.didx  = req_off_i[ADDR_W-1:2];
                     s_nxt.dbe   = be;
                     s_nxt.dw    = r_mem && (|be[1:0]) && (|be[3:2]);
                     s_nxt.ddata = 32'h0;
                     s_nxt.late  = 1'b0;
                  end
               end else begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, 32'h0);
               end
            end else if (take && is_wr) begin
               if (r_if) begin
                  for (int b = 0; b < 4; b++) begin
                     if (be[b]) begin
                        s_nxt.ifreg[if_idx][8*b +: 8] =
                           req_wdata_i[8*b +: 8];
                     end
                  end
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, 32'h0);
               end else if (r_core && bad_be) begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_ABORT, 32'h0);
               end else if (r_core) begin
                  s_nxt.st = ST_WR;
               end else begin
                  s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, 32'h0);
               end
            end else if (take) begin
               s_nxt = answer(s_nxt, tpfdr_pkg::ANS_ABORT, 32'h0);
            end
         end
         ST_WR: begin
            // Wait states while full: the burst is never cut short
            if (fq.in_ready) begin
               s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, 32'h0);
            end
         end
         ST_ZERO: begin
            if (s_r.zcnt == 2'h1) begin
               s_nxt = answer(s_nxt, tpfdr_pkg::ANS_DONE, 32'h0);
            end else begin
               s_nxt.zcnt = s_r.zcnt - 2'h1;
            end
         end
      endcase

      // Deferred read engine
      unique case (s_r.dst)
         D_LAUNCH: begin
            if (s_r.dcnt != 7'h00) begin
               s_nxt.dcnt = s_r.dcnt - 7'h01;
            end else if (!s_r.creq) begin
               s_nxt.dst    = D_CORE;
               s_nxt.dcnt   = 7'h00;
               s_nxt.creq   = 1'b1;
               s_nxt.cwe    = 1'b0;
               s_nxt.creg   = s_r.dreg;
               s_nxt.chi    = !s_r.dw && !(|s_r.dbe[1:0]);
               s_nxt.caddr  = {s_r.didx, !s_r.dw && !(|s_r.dbe[1:0])};
            end
         end
         D_CORE: begin
            if (s_r.dcnt != 7'h7f) begin
               s_nxt.dcnt = s_r.dcnt + 7'h01;
            end
            if (s_r.dcnt > limit) begin
               s_nxt.late = 1'b1;
            end
            if (core_ack_i) begin
               if (s_r.chi) begin
                  s_nxt.ddata[31:16] = core_rdata_i;
               end else begin
                  s_nxt.ddata[15:0] = core_rdata_i;
               end
               if (s_r.dw && !s_r.chi) begin
                  s_nxt.chi   = 1'b1;
                  s_nxt.caddr = {s_r.didx, 1'b1};
               end else begin
                  s_nxt.creq = 1'b0;
                  s_nxt.dst  = D_PRESENT;
                  s_nxt.dcnt = 7'(tpfdr_pkg::DEFER_PRESENT_CYC - 1);
               end
            end
         end
         D_PRESENT: begin
            if (s_r.dcnt == 7'h00) begin
               s_nxt.dst = D_READY;
            end else begin
               s_nxt.dcnt = s_r.dcnt - 7'h01;
            end
         end
         D_IDLE, D_READY: begin
         end
         default: begin
            s_nxt.dst = D_IDLE;
         end
      endcase

      // Write drain, one 16-bit core word at a time
      if (drain_ok && (e_lo || e_hi)) begin
         s_nxt.creq   = 1'b1;
         s_nxt.cwe    = 1'b1;
         s_nxt.creg   = e_reg;
         s_nxt.chi    = !e_lo;
         s_nxt.caddr  = {e_idx, !e_lo};
         s_nxt.cwdata = e_lo ? e_data[15:0] : e_data[31:16];
      end else if (s_r.creq && s_r.cwe && core_ack_i) begin
         if (!s_r.chi && e_hi) begin
            s_nxt.chi    = 1'b1;
            s_nxt.caddr  = {e_idx, 1'b1};
            s_nxt.cwdata = e_data[31:16];
         end else begin
            s_nxt.creq = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ans_valid_o  = s_r.ans_valid;
   assign ans_code_o   = s_r.ans_code;
   assign ans_rdata_o  = s_r.ans_data;
   assign core_req_o   = s_r.creq;
   assign core_we_o    = s_r.cwe;
   assign core_reg_o   = s_r.creg;
   assign core_addr_o  = s_r.caddr;
   assign core_wdata_o = s_r.cwdata;
   assign late_o       = s_r.late;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   logic rd_defer;
   assign rd_defer = take && is_rd && r_core && !(r_reg && bad_be)
                  && !zero_rd;

   sequence s_done;
      ans_valid_o && ans_code_o == 2'(tpfdr_pkg::ANS_DONE);
   endsequence
   sequence s_retry;
      ans_valid_o && ans_code_o == 2'(tpfdr_pkg::ANS_RETRY);
   endsequence
   sequence s_abort;
      ans_valid_o && ans_code_o == 2'(tpfdr_pkg::ANS_ABORT);
   endsequence
   sequence s_quiet2;
      !ans_valid_o [*2];
   endsequence

   a_zero_read: assert property (
      take && is_rd && r_core && !(r_reg && bad_be) && zero_rd
      |=> s_quiet2 ##1 (s_done and ans_rdata_o == 32'h0))
      else $error("zero read not answered with zeros on third clock");
   a_wr_abort: assert property (
      take && is_wr && r_core && bad_be |=> s_abort)
      else $error("single-byte core write was not aborted");
   a_rd_abort: assert property (
      take && is_rd && r_reg && bad_be |=> s_abort)
      else $error("single-byte register read was not aborted");
   a_enqueue_cond: assert property (
      s_r.dst == D_IDLE && s_nxt.dst == D_LAUNCH
      |-> fifo_empty && rd_defer ##1 s_retry)
      else $error("deferred read queued while FIFO busy");
   a_retry_wait: assert property (
      rd_defer && !key_hit |=> s_retry)
      else $error("deferred read without data not retried");
   a_read_done: assert property (
      rd_defer && key_hit
      |=> s_done ##0 ans_rdata_o == $past(s_r.ddata) ##0 s_r.dst == D_IDLE)
      else $error("repeated read did not complete with its data");
   a_fifo_flag: assert property (
      take && is_rd && r_if && if_idx == 3'h0
      |=> s_done ##0 ans_rdata_o[30] == $past(!fifo_empty))
      else $error("interface register misreports FIFO state");
   a_ifreg_direct: assert property (
      take && is_wr && r_if |-> s_nxt.st == ST_IDLE ##1 s_done)
      else $error("interface register write went through FIFO");
   a_wr_queued: assert property (
      s_r.st == ST_WR |=> !ans_valid_o or s_done)
      else $error("queued write terminated other than complete");
   a_wrinv_alias: assert property (
      take && req_cmd_i == tpfdr_pkg::CMD_MEM_WRINV && r_core && !bad_be
      |=> s_r.st == ST_WR)
      else $error("write-and-invalidate not handled as write");
   a_reg_lower: assert property (
      core_req_o && core_we_o && core_reg_o |-> !core_addr_o[0])
      else $error("core register written in upper word");
   a_present_time: assert property (
      s_r.dst == D_CORE && s_nxt.dst == D_PRESENT
      |=> (s_r.dst == D_PRESENT) [*4] ##1 s_r.dst == D_READY)
      else $error("read data not presented after fixed delay");
   a_late_flag: assert property (
      s_r.dst == D_CORE && s_r.dcnt > limit |=> late_o)
      else $error("contention overrun not flagged");
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the bus target with its write FIFO
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int AW = 12;
   logic          clock_i = 1'b0, resetn_i = 1'b0, req_valid_i = 1'b0;
   logic          req_bar_i = 1'b0, core_active_i = 1'b0;
   logic          priority_access_i = 1'b0;
   logic [3:0]    req_cmd_i = 4'h0, req_be_n_i = 4'hf;
   logic [AW-1:0] req_off_i = '0;
   logic [31:0]   req_wdata_i = 32'h0, ans_rdata_o, rd;
   logic          ans_valid_o, core_req_o, core_we_o, core_reg_o;
   logic          core_ack_i, late_o;
   logic [1:0]    ans_code_o, code;
   logic [AW-2:0] core_addr_o;
   logic [15:0]   core_wdata_o, core_rdata_i;
   logic [7:0]    dly = 8'h00;
   logic [31:0]   seed = 32'd7150;
   logic [15:0]   em [int];
   logic [27:0]   ew [$];
   int            fails = 0, n_checks = 0, n;

   always #20 clock_i = ~clock_i;
   tpfdr_target #(.ADDR_W(AW)) uut (.clock_i(clock_i),
      .resetn_i(resetn_i), .req_valid_i(req_valid_i),
      .req_cmd_i(req_cmd_i), .req_bar_i(req_bar_i),
      .req_off_i(req_off_i), .req_be_n_i(req_be_n_i),
      .req_wdata_i(req_wdata_i), .ans_valid_o(ans_valid_o),
      .ans_code_o(ans_code_o), .ans_rdata_o(ans_rdata_o),
      .core_req_o(core_req_o), .core_we_o(core_we_o),
      .core_reg_o(core_reg_o), .core_addr_o(core_addr_o),
      .core_wdata_o(core_wdata_o), .core_rdata_i(core_rdata_i),
      .core_ack_i(core_ack_i), .core_active_i(core_active_i),
      .priority_access_i(priority_access_i), .late_o(late_o));
   tpfdr_core_model #(.AW(AW-1)) m (.clock_i(clock_i),
      .core_req_i(core_req_o), .core_we_i(core_we_o),
      .core_reg_i(core_reg_o), .core_addr_i(core_addr_o),
      .core_wdata_i(core_wdata_o), .dly_i(dly),
      .core_rdata_o(core_rdata_i), .core_ack_o(core_ack_i));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Request held until the edge that samples the answer pulse
   task automatic req(input logic [3:0] c, input logic b,
         input logic [AW-1:0] o, input logic [3:0] be, input logic [31:0] d);
      @(posedge clock_i);
      req_valid_i <= 1'b1;
      req_cmd_i <= c;
      req_bar_i <= b;
      req_off_i <= o;
      req_be_n_i <= be;
      req_wdata_i <= d;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (ans_valid_o !== 1'b1 && n < 500);
      chk(ans_valid_o, 32'h1);
      code = ans_code_o;
      rd = ans_rdata_o;
      req_valid_i <= 1'b0;
   endtask

   task automatic push(input logic b, input logic [AW-2:0] a,
         input logic [15:0] w);
      em[{b, a}] = w;
      ew.push_back({b, a, w});
   endtask

   task automatic wr(input logic [3:0] c, input logic b,
         input logic [AW-1:0] o, input logic [3:0] be, input logic [31:0] d);
      logic ab;
      ab = (be[0] ^ be[1]) || (be[2] ^ be[3]);
      req(c, b, o, be, d);
      chk(code, ab ? 32'h2 : 32'h0);
      if (!ab && !be[1]) push(b, {o[AW-1:2], 1'b0}, d[15:0]);
      if (!ab && !be[3] && !b) push(b, {o[AW-1:2], 1'b1}, d[31:16]);
   endtask

   task automatic drain();
      n = 0;
      while (m.wlog.size() < ew.size() && n < 3000) begin
         @(posedge clock_i);
         n++;
      end
      chk(m.wlog.size(), ew.size());
      while (ew.size() > 0) chk(m.wlog.pop_front(), ew.pop_front());
   endtask

   task automatic rdc(input logic b, input logic [AW-1:0] o,
         input logic [3:0] be);
      logic [31:0] e;
      e = 32'h0;
      if (be[1:0] != 2'b11) e[15:0] = em[{b, o[AW-1:2], 1'b0}];
      if (be[3:2] != 2'b11 && !b) e[31:16] = em[{b, o[AW-1:2], 1'b1}];
      req(tpfdr_pkg::CMD_MEM_READ, b, o, be, 32'h0);
      chk(code, 32'h1);
      for (int t = 0; t < 300 && code === 2'h1; t++) begin
         req(tpfdr_pkg::CMD_MEM_READ, b, o, be, 32'h0);
      end
      chk(code, 32'h0);
      chk(rd, e);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #(40 * 30000);
      fails++;
      complete_run();
   end

   initial begin
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      wr(tpfdr_pkg::CMD_MEM_WRITE, 1'b0, 12'h010, 4'he, rnd());
      wr(tpfdr_pkg::CMD_MEM_WRITE, 1'b1, 12'h008, 4'h7, rnd());
      wr(tpfdr_pkg::CMD_MEM_WRITE, 1'b1, 12'h008, 4'h0, rnd());
      wr(tpfdr_pkg::CMD_MEM_WRITE, 1'b1, 12'h00c, 4'h3, rnd());
      drain();
      $display("end of test write checks");
      for (int i = 0; i < 16; i++) begin
         wr(i[0] ? tpfdr_pkg::CMD_MEM_WRINV : tpfdr_pkg::CMD_MEM_WRITE,
            1'b0, 12'h040 + 12'(4 * i), 4'h0, rnd());
      end
      drain();
      $display("end of test burst");
      req(tpfdr_pkg::CMD_MEM_WRITE, 1'b1, 12'h804, 4'h0, 32'h5a5a_0f0f);
      req(tpfdr_pkg::CMD_MEM_READ, 1'b1, 12'h804, 4'h0, 32'h0);
      chk(rd, 32'h5a5a_0f0f);
      dly = 8'd30;
      wr(tpfdr_pkg::CMD_MEM_WRITE, 1'b0, 12'h100, 4'h0, rnd());
      req(tpfdr_pkg::CMD_MEM_READ, 1'b1, 12'h800, 4'h0, 32'h0);
      chk(rd[30], 32'h1);
      rdc(1'b0, 12'h100, 4'h0);
      drain();
      req(tpfdr_pkg::CMD_MEM_READ, 1'b1, 12'h800, 4'h0, 32'h0);
      chk(rd[30], 32'h0);
      $display("end of test iface and ordering");
      dly = 8'h00;
      rdc(1'b0, 12'h044, 4'h0);
      chk(late_o, 32'h0);
      rdc(1'b0, 12'h048, 4'hd);
      rdc(1'b1, 12'h008, 4'hc);
      req(tpfdr_pkg::CMD_MEM_READ, 1'b1, 12'h008, 4'he, 32'h0);
      chk(code, 32'h2);
      for (int z = 0; z < 2; z++) begin
         req(tpfdr_pkg::CMD_MEM_READ, z[0], 12'h008, z[0] ? 4'h3 : 4'hf, 0);
         chk(n, tpfdr_pkg::ZERO_READ_CYC + 1);
         chk(rd, 32'h0);
      end
      $display("end of test reads");
      dly = 8'd20;
      core_active_i <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         priority_access_i <= p[0];
         rdc(1'b0, 12'h04c, 4'hc);
         chk(late_o, p[0] ? 32'h1 : 32'h0);
      end
      $display("end of test contention");
      complete_run();
   end
endmodule
`default_nettype wire

// File: test/tpfdr_core_model.sv
// Terminal core stand-in: word store answering with an adjustable delay
`timescale 1ns/1ns
`default_nettype none
module tpfdr_core_model #(
   parameter int AW = 11
) (
   input  wire logic          clock_i,
   input  wire logic          core_req_i,
   input  wire logic          core_we_i,
   input  wire logic          core_reg_i,
   input  wire logic [AW-1:0] core_addr_i,
   input  wire logic [15:0]   core_wdata_i,
   input  wire logic [7:0]    dly_i,
   output logic [15:0]        core_rdata_o,
   output logic               core_ack_o
);
   logic [15:0]   mem [int];
   logic [AW+16:0] wlog [$];
   logic [7:0]    cnt = 8'h00;
   always @(posedge clock_i) begin
      core_ack_o <= 1'b0;
      // Read data is only good with the ack, so it toggles otherwise
      core_rdata_o <= ~core_rdata_o;
      if (core_req_i && !core_ack_o) begin
         if (cnt >= dly_i) begin
            cnt <= 8'h00;
            core_ack_o <= 1'b1;
            if (core_we_i) begin
               mem[{core_reg_i, core_addr_i}] = core_wdata_i;
               wlog.push_back({core_reg_i, core_addr_i, core_wdata_i});
            end else begin
               core_rdata_o <= mem[{core_reg_i, core_addr_i}];
            end
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire
